// ---- rtl/swp_cfg.svh ----
// Offsets, field positions and reset values of the sub-window position block.
// Assumes a Wishbone slave with byte-wide registers in the low lane of each word.
`ifndef SWP_CFG_SVH
`define SWP_CFG_SVH

// Register indices; byte address is four times the index
`define SWP_IDX_XS_LO   8'h84
`define SWP_IDX_XS_HI   8'h85
`define SWP_IDX_YS_LO   8'h88
`define SWP_IDX_YS_HI   8'h89
`define SWP_IDX_XE_LO   8'h8C
`define SWP_IDX_XE_HI   8'h8D
`define SWP_IDX_YE_LO   8'h90
`define SWP_IDX_YE_HI   8'h91
`define SWP_IDX_CTRL    8'hA0
`define SWP_IDX_STAT    8'hA1

// Field positions
`define SWP_HI_BITS     2
`define SWP_CTRL_ROT_LO 0
`define SWP_CTRL_BPP_LO 2
`define SWP_CTRL_EN     5

// Reset values
`define SWP_POS_RST     10'h000
`define SWP_CTRL_RST    8'h00

`endif

// ---- rtl/swp_cmp.sv ----
// Hit test of one scan position against the sub-window bounds.
// Assumes scan coordinates in panel pixels and lines, same clock as caller.
`timescale 1ns/10ps
module swp_cmp
  import swp_pkg::*;
(
  // Bounds
  swp_win_if.dst         win,
  // Scan position
  input  wire logic [9:0] pix_i,
  input  wire logic [9:0] line_i,
  // Result
  output logic            hit_o
);

  // Shift that turns a pixel count into a 32-bit group count
  function automatic logic [2:0] grp_shift(input swp_bpp_t b);
    case (b)
      SWP_BPP_1:  grp_shift = 3'h5;
      SWP_BPP_2:  grp_shift = 3'h4;
      SWP_BPP_4:  grp_shift = 3'h3;
      SWP_BPP_8:  grp_shift = 3'h2;
      SWP_BPP_16: grp_shift = 3'h1;
      default:    grp_shift = 3'h1;
    endcase
  endfunction : grp_shift

  wire logic [2:0] sh        = grp_shift(win.bpp);
  wire logic [9:0] pix_grp   = pix_i >> sh;
  wire logic       rot_side  = (win.rot == SWP_ROT_90) || (win.rot == SWP_ROT_270);
  // X unit: groups unrotated, lines rotated
  wire logic [9:0] x_unit    = rot_side ? line_i : pix_grp;
  // Y unit: lines unrotated, groups rotated
  wire logic [9:0] y_unit    = rot_side ? pix_grp : line_i;
  wire logic       in_x      = (x_unit >= win.x_start) && (x_unit <= win.x_end);
  wire logic       in_y      = (y_unit >= win.y_start) && (y_unit <= win.y_end);

  assign hit_o = win.enable && in_x && in_y;

endmodule : swp_cmp

// ---- rtl/swp_pkg.sv ----
// Types shared by the sub-window position block.
// Assumes swp_cfg.svh supplies offsets and reset values.
package swp_pkg;

  typedef enum logic [1:0] {
    SWP_ROT_0,
    SWP_ROT_90,
    SWP_ROT_180,
    SWP_ROT_270
  } swp_rot_t;

  typedef enum logic [2:0] {
    SWP_BPP_1,
    SWP_BPP_2,
    SWP_BPP_4,
    SWP_BPP_8,
    SWP_BPP_16
  } swp_bpp_t;

  typedef logic [9:0] swp_pos_t;

endpackage : swp_pkg

// ---- rtl/swp_regs.sv ----
// Sub-window position registers with Wishbone slave and window hit flag.
// Assumes classic Wishbone on clk_i, scan position from display timing on clk_i.
//
// What this block does
// - 270 rotation: X start is panel width minus corner line, line steps.
// - Y start is ten bits: low byte and two low bits of high byte.
// - Y start steps lines unrotated, 32/bpp pixel groups when rotated.
// - Unrotated Y start is the top-left corner line, growing downwards.
// - X end is ten bits: low byte and two low bits of high byte.
// - X end steps 32/bpp pixel groups unrotated, lines when rotated.
// - Y end is ten bits: low byte and two low bits of high byte.
// - Y end steps lines unrotated, 32/bpp pixel groups when rotated.
`timescale 1ns/10ps
`include "swp_cfg.svh"
module swp_regs
  import swp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // Scan position
  input  wire logic [9:0]  pix_i,
  input  wire logic [9:0]  line_i,
  // Window select
  output logic             sub_sel_o
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  swp_pos_t   xs_r, ys_r, xe_r, ye_r;
  logic [7:0] ctrl_r;
  logic       hit;
  logic       hit_r;

  // Decode of a register index against the word address
  function automatic logic idx_hit(input logic [9:0] a, input logic [7:0] idx);
    idx_hit = (a[9:2] == idx) && (a[1:0] == 2'h0);
  endfunction : idx_hit

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire logic req     = cyc_i && stb_i && !ack_o && !err_o;
  wire logic wr_lane = we_i && sel_i[0];
  wire logic s_xs_lo = idx_hit(adr_i, `SWP_IDX_XS_LO);
  wire logic s_xs_hi = idx_hit(adr_i, `SWP_IDX_XS_HI);
  wire logic s_ys_lo = idx_hit(adr_i, `SWP_IDX_YS_LO);
  wire logic s_ys_hi = idx_hit(adr_i, `SWP_IDX_YS_HI);
  wire logic s_xe_lo = idx_hit(adr_i, `SWP_IDX_XE_LO);
  wire logic s_xe_hi = idx_hit(adr_i, `SWP_IDX_XE_HI);
  wire logic s_ye_lo = idx_hit(adr_i, `SWP_IDX_YE_LO);
  wire logic s_ye_hi = idx_hit(adr_i, `SWP_IDX_YE_HI);
  wire logic s_ctrl  = idx_hit(adr_i, `SWP_IDX_CTRL);
  wire logic s_stat  = idx_hit(adr_i, `SWP_IDX_STAT);
  wire logic mapped  = s_xs_lo | s_xs_hi | s_ys_lo | s_ys_hi | s_xe_lo | s_xe_hi
                     | s_ys_lo | s_ye_lo | s_ye_hi | s_ctrl | s_stat;
  wire logic wr      = req && mapped && wr_lane;

  // Pair of byte registers forming one ten-bit position
  function automatic swp_pos_t pos_wr(input swp_pos_t cur, input logic lo, input logic hi,
                                      input logic [7:0] d);
    pos_wr = cur;
    if (lo) begin
      pos_wr[7:0] = d;
    end
    if (hi) begin
      pos_wr[9:8] = d[`SWP_HI_BITS-1:0];
    end
  endfunction : pos_wr

  // Y start split over low and high bytes
  wire swp_pos_t ys_nxt = wr ? pos_wr(ys_r, s_ys_lo, s_ys_hi, dat_i[7:0]) : ys_r;
  // X end split over low and high bytes
  wire swp_pos_t xe_nxt = wr ? pos_wr(xe_r, s_xe_lo, s_xe_hi, dat_i[7:0]) : xe_r;
  // Y end split over low and high bytes
  wire swp_pos_t ye_nxt = wr ? pos_wr(ye_r, s_ye_lo, s_ye_hi, dat_i[7:0]) : ye_r;
  // X start holds the value as written: a line count when rotated, a 32/bpp pixel group count unrotated
  wire swp_pos_t xs_nxt = wr ? pos_wr(xs_r, s_xs_lo, s_xs_hi, dat_i[7:0]) : xs_r;
  wire logic [7:0] ctrl_nxt = (wr && s_ctrl) ? dat_i[7:0] : ctrl_r;

  // Read mux: unused high bits of each high byte read zero
  wire logic [7:0] rd_byte =
      s_xs_lo ? xs_r[7:0] :
      s_xs_hi ? {6'h00, xs_r[9:8]} :
      s_ys_lo ? ys_r[7:0] :
      s_ys_hi ? {6'h00, ys_r[9:8]} :
      s_xe_lo ? xe_r[7:0] :
      s_xe_hi ? {6'h00, xe_r[9:8]} :
      s_ye_lo ? ye_r[7:0] :
      s_ye_hi ? {6'h00, ye_r[9:8]} :
      s_ctrl  ? ctrl_r :
      s_stat  ? {7'h00, hit_r} : 8'h00;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xs_r   <= `SWP_POS_RST;
      ys_r   <= `SWP_POS_RST;
      xe_r   <= `SWP_POS_RST;
      ye_r   <= `SWP_POS_RST;
      ctrl_r <= `SWP_CTRL_RST;
    end else begin
      xs_r   <= xs_nxt;
      ys_r   <= ys_nxt;
      xe_r   <= xe_nxt;
      ye_r   <= ye_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req && mapped;
      err_o <= req && !mapped;
      dat_o <= (req && mapped && !we_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // Window compare
  // ------------------------------------------------------------
  swp_win_if win ();

  // Unrotated Y start used directly as a line
  assign win.y_start = ys_r;
  assign win.x_start = xs_r;
  assign win.x_end   = xe_r;
  assign win.y_end   = ye_r;
  assign win.rot     = swp_rot_t'(ctrl_r[`SWP_CTRL_ROT_LO +: 2]);
  assign win.bpp     = swp_bpp_t'(ctrl_r[`SWP_CTRL_BPP_LO +: 3]);
  assign win.enable  = ctrl_r[`SWP_CTRL_EN];

  swp_cmp u_cmp (
    .win    (win),
    .pix_i  (pix_i),
    .line_i (line_i),
    .hit_o  (hit)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hit_r     <= 1'b0;
      sub_sel_o <= 1'b0;
    end else begin
      hit_r     <= hit;
      sub_sel_o <= hit;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  wire logic ctrl_rot_side = (ctrl_r[1:0] == 2'h1) || (ctrl_r[1:0] == 2'h3);

  a_ys_low_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && s_ys_lo && wr_lane) |=> (ys_r[7:0] == $past(dat_i[7:0])) && ack_o)
    else $error("y start low byte not stored");

  a_ys_high_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && s_ys_hi && wr_lane) |=> (ys_r[9:8] == $past(dat_i[1:0]))
      && (ys_r[7:0] == $past(ys_r[7:0])))
    else $error("y start high byte not stored");

  a_xe_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && s_xe_hi && wr_lane) |=> (xe_r[9:8] == $past(dat_i[1:0])))
    else $error("x end high bits not stored");

  a_ye_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && s_ye_lo && wr_lane) |=> (ye_r[7:0] == $past(dat_i[7:0])))
    else $error("y end low byte not stored");

  a_hi_read_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && !we_i && (s_ye_hi || s_xe_hi || s_ys_hi)) |=> (dat_o[7:2] == 6'h00) && ack_o)
    else $error("unused high bits read non-zero");

  a_unrot_y_line: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ctrl_r[`SWP_CTRL_EN] && !ctrl_rot_side && (line_i < ys_r)) |=> !sub_sel_o)
    else $error("sub-window shown above start line");

  a_rot_y_group: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ctrl_r[`SWP_CTRL_EN] && ctrl_rot_side && (u_cmp.pix_grp < ys_r)) |=> !sub_sel_o)
    else $error("rotated y start not in pixel groups");

  a_xs_line_270: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ctrl_r[`SWP_CTRL_EN] && (ctrl_r[1:0] == 2'h3) && (line_i < xs_r)) |=> !sub_sel_o)
    else $error("270 x start not a line count");

  a_xe_group: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ctrl_r[`SWP_CTRL_EN] && !ctrl_rot_side && (u_cmp.pix_grp > xe_r)) |=> !sub_sel_o)
    else $error("x end not in pixel groups");

  a_ye_rot_group: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ctrl_r[`SWP_CTRL_EN] && ctrl_rot_side && (u_cmp.pix_grp > ye_r)) |=> !sub_sel_o)
    else $error("rotated y end not in pixel groups");

  a_inside_shows: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (win.enable && !ctrl_rot_side && (u_cmp.pix_grp >= xs_r) && (u_cmp.pix_grp <= xe_r)
      && (line_i >= ys_r) && (line_i <= ye_r)) |=> sub_sel_o)
    else $error("sub-window not shown inside bounds");

  a_inside_rot: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (win.enable && ctrl_rot_side && (line_i >= xs_r) && (line_i <= xe_r)
      && (u_cmp.pix_grp >= ys_r) && (u_cmp.pix_grp <= ye_r)) |=> sub_sel_o)
    else $error("rotated sub-window not shown inside bounds");

  a_disabled_main: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !ctrl_r[`SWP_CTRL_EN] |=> !sub_sel_o)
    else $error("sub-window shown while disabled");

  a_xe_low_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && s_xe_lo && wr_lane) |=> (xe_r[7:0] == $past(dat_i[7:0])) && ack_o)
    else $error("x end low byte not stored");

  a_ye_high_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && s_ye_hi && wr_lane) |=> (ye_r[9:8] == $past(dat_i[1:0]))
      && (ye_r[7:0] == $past(ye_r[7:0])))
    else $error("y end high byte not stored");

  a_xs_low_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && s_xs_lo && wr_lane) |=> (xs_r[7:0] == $past(dat_i[7:0])))
    else $error("x start low byte not stored");

  a_xs_high_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && s_xs_hi && wr_lane) |=> (xs_r[9:8] == $past(dat_i[1:0])))
    else $error("x start high bits not stored");

  a_ys_read_back: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && !we_i && s_ys_lo) |=> (dat_o == {24'h00_0000, $past(ys_r[7:0])}) && ack_o)
    else $error("y start low byte read wrong");

  a_xe_read_back: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && !we_i && s_xe_hi) |=> (dat_o[1:0] == $past(xe_r[9:8])))
    else $error("x end high bits read wrong");

  a_ye_read_back: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && !we_i && s_ye_lo) |=> (dat_o[7:0] == $past(ye_r[7:0])))
    else $error("y end low byte read wrong");

  a_lane_off_keep: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && we_i && !sel_i[0]) |=> (ys_r == $past(ys_r)) && (xe_r == $past(xe_r))
      && (ye_r == $past(ye_r)))
    else $error("position changed by write with low lane off");

  a_unmapped_keep: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && !mapped) |=> err_o && !ack_o && (ys_r == $past(ys_r)))
    else $error("unmapped access not refused");

  a_unrot_y_end: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ctrl_r[`SWP_CTRL_EN] && !ctrl_rot_side && (line_i > ye_r)) |=> !sub_sel_o)
    else $error("sub-window shown below end line");

  a_rot_x_end_line: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ctrl_r[`SWP_CTRL_EN] && ctrl_rot_side && (line_i > xe_r)) |=> !sub_sel_o)
    else $error("rotated x end not a line count");

  a_unrot_x_start: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ctrl_r[`SWP_CTRL_EN] && !ctrl_rot_side && (u_cmp.pix_grp < xs_r)) |=> !sub_sel_o)
    else $error("sub-window shown left of start group");

endmodule : swp_regs

// ---- rtl/swp_win_if.sv ----
// Window bounds carried from the register file to the comparator.
// Assumes one clock domain.
`timescale 1ns/10ps
interface swp_win_if;
  import swp_pkg::*;
  swp_pos_t x_start;
  swp_pos_t y_start;
  swp_pos_t x_end;
  swp_pos_t y_end;
  swp_rot_t rot;
  swp_bpp_t bpp;
  logic     enable;
  modport src (output x_start, y_start, x_end, y_end, rot, bpp, enable);
  modport dst (input x_start, y_start, x_end, y_end, rot, bpp, enable);
endinterface : swp_win_if

// ---- verif/tb_swp_regs.sv ----
// Self-checking bench for the sub-window position registers and hit flag.
// Assumes swp_regs answers classic Wishbone and registers hits one cycle late.
`timescale 1ns/10ps
`include "swp_cfg.svh"
module tb_swp_regs
  import swp_pkg::*;
;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, sub_sel_o;
  logic [9:0]  adr_i, pix_i, line_i;
  logic [3:0]  sel_i;
  logic [3:0]  sel_w;
  logic [31:0] dat_i, dat_o;
  int          errors, checks;
  logic [7:0]  pos_idx [6] = '{`SWP_IDX_YS_LO, `SWP_IDX_YS_HI, `SWP_IDX_XE_LO,
                                `SWP_IDX_XE_HI, `SWP_IDX_YE_LO, `SWP_IDX_YE_HI};

  swp_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .err_o(err_o), .pix_i(pix_i), .line_i(line_i),
    .sub_sel_o(sub_sel_o));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic end_sim;
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h", $time, msg, got);
    end
  endtask : chk

  // ----------------------------------------------------------------
  // Bus cycle: hold request until ack or err is sampled high
  // ----------------------------------------------------------------
  task automatic wb_cyc(input logic [7:0] idx, input logic we, input logic [7:0] d,
                        output logic [31:0] q, output logic er);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= we;
    sel_i <= sel_w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
    q  = dat_o;
    er = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 20) begin
      errors++;
      end_sim();
    end
  endtask : wb_cyc

  task automatic wb_wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    logic        er;
    wb_cyc(idx, 1'b1, d, q, er);
    chk({31'h0, er}, 32'h0, "write refused");
  endtask : wb_wr

  task automatic wb_rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    logic        er;
    wb_cyc(idx, 1'b0, 8'h00, q, er);
    chk(q, {24'h000000, exp}, "read data");
  endtask : wb_rd

  task automatic set_pos(input int i, input logic [9:0] v);
    wb_wr(pos_idx[2*i], v[7:0]);
    wb_wr(pos_idx[2*i+1], {6'h00, v[9:8]});
  endtask : set_pos

  task automatic scan(input logic [9:0] p, input logic [9:0] l, input logic exp);
    @(posedge clk_i);
    pix_i  <= p;
    line_i <= l;
    @(posedge clk_i);
    @(negedge clk_i);
    chk({31'h0, sub_sel_o}, {31'h0, exp}, "window select");
  endtask : scan

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_fields;
    for (int i = 0; i < 6; i++) wb_rd(pos_idx[i], 8'h00);
    for (int i = 0; i < 6; i += 2) begin
      wb_wr(pos_idx[i], 8'hFF);
      wb_wr(pos_idx[i+1], 8'hFD);
      wb_rd(pos_idx[i], 8'hFF);
      wb_rd(pos_idx[i+1], 8'h01);
    end
    wb_wr(`SWP_IDX_XS_HI, 8'hFE);
    wb_rd(`SWP_IDX_XS_HI, 8'h02);
    wb_rd(`SWP_IDX_XS_LO, 8'h00);
  endtask : t_fields

  task automatic t_unmapped;
    logic [31:0] q;
    logic        er;
    wb_cyc(8'hFF, 1'b1, 8'h55, q, er);
    chk({31'h0, er}, 32'h1, "unmapped write");
    wb_rd(pos_idx[0], 8'hFF);
    // Low lane off: acknowledged, nothing stored
    sel_w = 4'hE;
    wb_wr(pos_idx[0], 8'h12);
    sel_w = 4'hF;
    wb_rd(pos_idx[0], 8'hFF);
  endtask : t_unmapped

  // Unrotated, then 180, at 4 bpp on a 320x240 panel; a 160x120 window at (80,60)
  // in either frame gives the same words: X in 8-pixel groups, Y in lines
  task automatic t_win0;
    logic [7:0] c;
    for (int k = 0; k < 2; k++) begin
      c = (k == 0) ? 8'h28 : 8'h2A;
      if (k == 0) begin
        wb_wr(`SWP_IDX_XS_LO, 8'(80 / 8));
        set_pos(0, 10'd60);
        set_pos(1, 10'((80 + 160) / 8 - 1));
        set_pos(2, 10'(60 + 120 - 1));
      end else begin
        wb_wr(`SWP_IDX_XS_LO, 8'((320 - 240) / 8));
        set_pos(0, 10'(240 - 180));
        set_pos(1, 10'((320 - 80) / 8 - 1));
        set_pos(2, 10'(240 - 60 - 1));
      end
      wb_wr(`SWP_IDX_XS_HI, 8'h00);
      wb_wr(`SWP_IDX_CTRL, c);
      wb_rd(`SWP_IDX_CTRL, c);
      scan(10'd80, 10'd60, 1'b1);
      scan(10'd79, 10'd60, 1'b0);
      scan(10'd80, 10'd59, 1'b0);
      scan(10'd239, 10'd179, 1'b1);
      wb_rd(`SWP_IDX_STAT, 8'h01);
      scan(10'd240, 10'd179, 1'b0);
      scan(10'd239, 10'd180, 1'b0);
      wb_rd(`SWP_IDX_STAT, 8'h00);
      wb_wr(`SWP_IDX_CTRL, c & 8'hDF);
      scan(10'd80, 10'd60, 1'b0);
    end
  endtask : t_win0

  // Rotated on a 320x240 panel: X counts lines, Y counts 32/bpp pixel groups,
  // every depth code; codes above 16 bpp act as 16 bpp
  task automatic t_rot;
    int g;
    wb_wr(`SWP_IDX_XS_LO, 8'h05);
    foreach (pos_idx[r]) if (r == 1 || r == 3) begin
      for (int b = 0; b < 8; b++) begin
        g = (b > 4) ? 2 : 32 >> b;
        if (r == 1) begin
          set_pos(0, 10'((240 - (240 - 2 * g)) / g));
          set_pos(1, 10'(7 - 1));
          set_pos(2, 10'((240 - (240 - 4 * g)) / g - 1));
        end else begin
          set_pos(0, 10'(2 * g / g));
          set_pos(1, 10'(320 - 313 - 1));
          set_pos(2, 10'(4 * g / g - 1));
        end
        wb_wr(`SWP_IDX_CTRL, {2'b00, 1'b1, b[2:0], r[1:0]});
        scan(10'(2 * g), 10'd5, 1'b1);
        scan(10'(2 * g - 1), 10'd5, 1'b0);
        scan(10'(4 * g - 1), 10'd6, 1'b1);
        scan(10'(4 * g), 10'd6, 1'b0);
        scan(10'(2 * g), 10'd4, 1'b0);
        scan(10'(2 * g), 10'd7, 1'b0);
      end
    end
  endtask : t_rot

  initial begin
    errors = 0;
    checks = 0;
    rst_i  = 1'b1;
    {cyc_i, stb_i, we_i} = 3'b000;
    adr_i  = 10'h000;
    sel_i  = 4'hF;
    sel_w  = 4'hF;
    dat_i  = 32'h00000000;
    pix_i  = 10'h3FF;
    line_i = 10'h3FF;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_fields();
    t_unmapped();
    t_win0();
    t_rot();
    end_sim();
  end
endmodule : tb_swp_regs
